/* verilog/cad_pkg.sv */
package cad_pkg;

  // ==========================================================
  // fixed decode windows
  localparam logic [31:0] REG_BASE = 32'h0F00_0000;
  localparam int REG_SPAN_BITS = 9;
  localparam logic [7:0] BOOT_REGION = 8'h1F;
  localparam int BOOT_MIN_BITS = 21;

  // ==========================================================
  // target numbering
  localparam int NUM_TARGETS = 10;
  localparam int NUM_PROG = 8;
  localparam int NUM_MEM = 5;
  localparam int T_BOOT = 0;
  localparam int T_REG = 1;
  localparam int T_PROG0 = 2;
  localparam int RECOVERY_MEM = 4;

  // ==========================================================
  // processor command lines
  localparam int CMD_DATA_BIT = 4;
  localparam int CMD_WRITE_BIT = 3;
  localparam int CMD_SINGLE_BIT = 2;
  localparam int BLOCK_WORDS = 8;

  // ==========================================================
  // buffers, strap, multiplexing
  localparam int WR_FIFO_WORDS = 8;
  localparam int PF_FIFO_WORDS = 2;
  localparam int DMA_FIFO_WORDS = 8;
  localparam int STRAP_BIT = 11;
  localparam logic [2:0] NUM_MUX_MODES = 3'h5;
  localparam logic [2:0] SD64_MUX_MODE = 3'h4;
  localparam logic [2:0] SD16_BASE_MUX = 3'h3;

  typedef enum logic [2:0] {
    MEM_FLASH,
    MEM_EDO,
    MEM_FPM,
    MEM_SD16,
    MEM_SD64
  } cad_mem_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WDATA,
    PH_RDATA
  } cad_phase_t;

endpackage

/* verilog/cad_fifo.sv */
`timescale 1ns/1ps
module cad_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  output logic ready_o,
  // drain side
  output logic valid_o,
  output logic [W-1:0] data_o,
  input wire logic take_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("cad_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ready;
    logic valid;
    logic [W-1:0] data;
  } cad_fifo_t;

  cad_fifo_t st_reg;
  cad_fifo_t st_next;

  // the output word counts toward DEPTH, so ready is exact
  always_comb begin
    logic popped;
    logic pushed;
    popped = 1'b0;
    pushed = 1'b0;
    st_next = st_reg;
    if (take_i && st_reg.valid) begin
      st_next.valid = 1'b0;
    end
    if (!st_next.valid && st_reg.cnt != '0) begin
      st_next.valid = 1'b1;
      st_next.data = st_reg.mem[st_reg.rp];
      st_next.rp = st_reg.rp + 1'b1;
      popped = 1'b1;
    end
    if (push_i && st_reg.ready) begin
      st_next.mem[st_reg.wp] = data_i;
      st_next.wp = st_reg.wp + 1'b1;
      pushed = 1'b1;
    end
    st_next.cnt = st_reg.cnt + {{AW{1'b0}}, pushed} - {{AW{1'b0}}, popped};
    st_next.ready = ({1'b0, st_next.cnt} + {{(AW+1){1'b0}}, st_next.valid})
                    < (AW+2)'(DEPTH);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ready_o = st_reg.ready;
  assign valid_o = st_reg.valid;
  assign data_o = st_reg.data;

endmodule

/* verilog/cad_decoder.sv */
// What this block does
// - latch address cycle from the muxed bus, classify it with the command lines
// - decode ten targets: boot, registers, base, four modules, two PCI, PCI I/O
// - register window fixed and live from reset; all other non-boot windows programmable
// - boot window placed by configured boot ROM size, not a free base
// - processor side byte order taken from memory mux address bit 11 at reset
// - every other side sees little-endian data only
// - data returned to the processor is paced by the external data valid output
// - all single and block, read and write bus cycles are accepted
// - processor writes to memory go through an eight word write FIFO
// - two word prefetch FIFO serves memory reads for processor or PCI
// - eight word FIFO carries DMA data between memory and PCI either way
// - flash in module slot 4 also answers as fault-recovery boot ROM
// - base memory holding SDRAM is never bank interleaved
// - each module window has its own interleave, mux mode and type
// - flash boot/module; EDO base/module; FPM module; SD16 base/module; SD64 module
// - five row/column mux modes, chosen per base and module window
`timescale 1ns/1ps
module cad_decoder #(
  parameter int BLOCK_WORDS = cad_pkg::BLOCK_WORDS,
  parameter int WR_DEPTH = cad_pkg::WR_FIFO_WORDS,
  parameter int PF_DEPTH = cad_pkg::PF_FIFO_WORDS,
  parameter int DMA_DEPTH = cad_pkg::DMA_FIFO_WORDS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // processor bus
  input wire logic [31:0] cpu_muxed_addr_data_bus_i,
  input wire logic [4:0] cpu_command_lines_i,
  input wire logic cpu_valid_n_i,
  output logic [31:0] cpu_read_data_o,
  output logic ext_data_valid_n_o,
  output logic cpu_wr_ready_o,
  output logic cpu_big_endian_bit_o,
  // reset strap
  input wire logic [11:0] memory_mux_address_bus_i,
  // window configuration
  input wire logic [1:0] boot_rom_size_i,
  input wire logic [cad_pkg::NUM_PROG-1:0] range_en_i,
  input wire logic [cad_pkg::NUM_PROG-1:0][31:0] range_base_i,
  input wire logic [cad_pkg::NUM_PROG-1:0][31:0] range_mask_i,
  input wire logic [cad_pkg::NUM_MEM-1:0][2:0] mem_type_i,
  input wire logic [cad_pkg::NUM_MEM-1:0] mem_interleave_i,
  input wire logic [cad_pkg::NUM_MEM-1:0][2:0] mem_mux_mode_i,
  // decoded request
  output logic req_o,
  output logic mem_req_o,
  output logic [cad_pkg::NUM_TARGETS-1:0] target_o,
  output logic [31:0] txn_addr_o,
  output logic txn_write_o,
  output logic txn_block_o,
  output logic recovery_boot_o,
  output logic [2:0] sel_mem_type_o,
  output logic sel_interleave_o,
  output logic [2:0] sel_mux_mode_o,
  output logic bus_err_o,
  output logic cfg_err_o,
  // read data from non-memory targets
  input wire logic alt_rd_valid_i,
  input wire logic [31:0] alt_rd_data_i,
  // memory write drain
  output logic mem_wr_valid_o,
  output logic [31:0] mem_wr_data_o,
  input wire logic mem_wr_take_i,
  // memory read fill and PCI share of prefetch
  input wire logic mem_rd_valid_i,
  input wire logic [31:0] mem_rd_data_i,
  output logic mem_rd_ready_o,
  input wire logic pf_to_pci_i,
  input wire logic pci_pf_take_i,
  output logic pci_pf_valid_o,
  output logic [31:0] pci_pf_data_o,
  // DMA path
  input wire logic dma_dir_i,
  input wire logic mem_dma_push_i,
  input wire logic [31:0] mem_dma_data_i,
  input wire logic pci_dma_push_i,
  input wire logic [31:0] pci_dma_data_i,
  output logic dma_ready_o,
  output logic dma_valid_o,
  output logic [31:0] dma_data_o,
  input wire logic dma_take_i
);

  generate
    if (BLOCK_WORDS < 1 || BLOCK_WORDS > 15) begin : g_bad_block
      $error("cad_decoder: BLOCK_WORDS must be 1 to 15");
    end
  endgenerate

  // ==========================================================
  // state
  typedef struct packed {
    cad_pkg::cad_phase_t phase;
    logic strap_done;
    logic big_endian;
    logic [3:0] words_left;
    logic is_mem;
    logic [cad_pkg::NUM_TARGETS-1:0] target;
    logic req;
    logic mem_req;
    logic write;
    logic block;
    logic [31:0] addr;
    logic recovery;
    logic [2:0] sel_type;
    logic sel_il;
    logic [2:0] sel_mux;
    logic bus_err;
    logic cfg_err;
    logic evalid_n;
    logic [31:0] rdata;
  } cad_state_t;

  cad_state_t st_reg;
  cad_state_t st_next;

  logic [31:0] bus;
  logic addr_cycle;
  logic data_cycle;
  logic [cad_pkg::NUM_PROG-1:0] prog_hit;
  logic [23:0] boot_mask;
  logic reg_hit;
  logic boot_hit;
  logic recovery_hit;
  logic wr_push;
  logic [31:0] wr_data;
  logic wr_ready;
  logic pf_valid;
  logic [31:0] pf_data;
  logic pf_cpu_take;
  logic pf_ready;

  assign bus = cpu_muxed_addr_data_bus_i;
  assign addr_cycle = !cpu_valid_n_i && !cpu_command_lines_i[cad_pkg::CMD_DATA_BIT];
  assign data_cycle = !cpu_valid_n_i && cpu_command_lines_i[cad_pkg::CMD_DATA_BIT];

  // processor byte order to little-endian and back
  function automatic logic [31:0] swap_order(input logic big, input logic [31:0] w);
    swap_order = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  // memory type allowed in memory window idx (0 base, 1..4 modules)
  function automatic logic type_ok(input int idx, input logic [2:0] ty, input logic [2:0] mux);
    logic ok;
    ok = 1'b0;
    if (idx == 0) begin
      ok = (ty == cad_pkg::MEM_EDO) ||
           (ty == cad_pkg::MEM_SD16 && mux == cad_pkg::SD16_BASE_MUX);
    end else begin
      ok = (ty <= cad_pkg::MEM_SD64);
    end
    if (mux >= cad_pkg::NUM_MUX_MODES) begin
      ok = 1'b0;
    end
    if (mux == cad_pkg::SD64_MUX_MODE && ty != cad_pkg::MEM_SD64) begin
      ok = 1'b0;
    end
    type_ok = ok;
  endfunction

  // ==========================================================
  // window match
  genvar gi;
  generate
    for (gi = 0; gi < cad_pkg::NUM_PROG; gi++) begin : g_range
      assign prog_hit[gi] = range_en_i[gi] &&
        (((bus ^ range_base_i[gi]) & range_mask_i[gi]) == 32'h0000_0000);
    end
  endgenerate

  assign reg_hit = bus[31:cad_pkg::REG_SPAN_BITS] ==
                   cad_pkg::REG_BASE[31:cad_pkg::REG_SPAN_BITS];
  assign boot_mask = 24'hFF_FFFF << (5'(cad_pkg::BOOT_MIN_BITS) + {3'h0, boot_rom_size_i});
  assign boot_hit = (bus[31:24] == cad_pkg::BOOT_REGION) &&
                    ((bus[23:0] & boot_mask) == boot_mask);
  assign recovery_hit = prog_hit[cad_pkg::RECOVERY_MEM] &&
                        mem_type_i[cad_pkg::RECOVERY_MEM] == cad_pkg::MEM_FLASH;

  // ==========================================================
  // next state
  always_comb begin
    int sel;
    logic [3:0] n_words;
    sel = -1;
    n_words = 4'h0;
    st_next = st_reg;
    st_next.req = 1'b0;
    st_next.mem_req = 1'b0;
    st_next.bus_err = 1'b0;
    st_next.evalid_n = 1'b1;
    wr_push = 1'b0;
    wr_data = swap_order(st_reg.big_endian, bus);
    pf_cpu_take = 1'b0;

    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.big_endian = memory_mux_address_bus_i[cad_pkg::STRAP_BIT];
    end

    case (st_reg.phase)
      cad_pkg::PH_IDLE: begin
        if (addr_cycle) begin
          for (int i = cad_pkg::NUM_PROG - 1; i >= 0; i--) begin
            if (prog_hit[i]) begin
              sel = i;
            end
          end
          st_next.addr = bus;
          st_next.write = cpu_command_lines_i[cad_pkg::CMD_WRITE_BIT];
          st_next.block = !cpu_command_lines_i[cad_pkg::CMD_SINGLE_BIT];
          st_next.target = '0;
          st_next.recovery = 1'b0;
          st_next.is_mem = 1'b0;
          st_next.cfg_err = 1'b0;
          st_next.sel_type = 3'h0;
          st_next.sel_il = 1'b0;
          st_next.sel_mux = 3'h0;
          if (reg_hit) begin
            st_next.target[cad_pkg::T_REG] = 1'b1;
          end else if (boot_hit || recovery_hit) begin
            st_next.target[cad_pkg::T_BOOT] = 1'b1;
            st_next.recovery = !boot_hit;
          end else if (sel >= 0) begin
            st_next.target[cad_pkg::T_PROG0 + sel] = 1'b1;
            if (sel < cad_pkg::NUM_MEM) begin
              st_next.is_mem = 1'b1;
              st_next.sel_type = mem_type_i[sel];
              st_next.sel_mux = mem_type_i[sel] == cad_pkg::MEM_FLASH ? 3'h0 :
                                mem_mux_mode_i[sel];
              st_next.sel_il = mem_interleave_i[sel] &&
                !(sel == 0 && mem_type_i[sel] == cad_pkg::MEM_SD16);
              st_next.cfg_err = !type_ok(sel, mem_type_i[sel], mem_mux_mode_i[sel]);
            end
          end
          if (st_next.target == '0 || st_next.cfg_err) begin
            st_next.bus_err = 1'b1;
          end else begin
            n_words = st_next.block ? 4'(BLOCK_WORDS) : 4'h1;
            st_next.words_left = n_words;
            st_next.req = 1'b1;
            st_next.mem_req = st_next.is_mem || st_next.target[cad_pkg::T_BOOT];
            st_next.is_mem = st_next.mem_req;
            st_next.phase = st_next.write ? cad_pkg::PH_WDATA : cad_pkg::PH_RDATA;
          end
        end
      end
      cad_pkg::PH_WDATA: begin
        if (data_cycle && (!st_reg.is_mem || wr_ready)) begin
          wr_push = st_reg.is_mem;
          st_next.words_left = st_reg.words_left - 4'h1;
          if (st_reg.words_left == 4'h1) begin
            st_next.phase = cad_pkg::PH_IDLE;
          end
        end
      end
      cad_pkg::PH_RDATA: begin
        if (st_reg.is_mem ? (pf_valid && !pf_to_pci_i) : alt_rd_valid_i) begin
          pf_cpu_take = st_reg.is_mem;
          st_next.rdata = swap_order(st_reg.big_endian,
                                     st_reg.is_mem ? pf_data : alt_rd_data_i);
          st_next.evalid_n = 1'b0;
          st_next.words_left = st_reg.words_left - 4'h1;
          if (st_reg.words_left == 4'h1) begin
            st_next.phase = cad_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        st_next.phase = cad_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.phase <= cad_pkg::PH_IDLE;
      st_reg.evalid_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // buffers
  cad_fifo #(.W(32), .DEPTH(WR_DEPTH)) u_wr_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .push_i(wr_push),
    .data_i(wr_data),
    .ready_o(wr_ready),
    .valid_o(mem_wr_valid_o),
    .data_o(mem_wr_data_o),
    .take_i(mem_wr_take_i)
  );

  cad_fifo #(.W(32), .DEPTH(PF_DEPTH)) u_pf_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .push_i(mem_rd_valid_i),
    .data_i(mem_rd_data_i),
    .ready_o(pf_ready),
    .valid_o(pf_valid),
    .data_o(pf_data),
    .take_i(pf_to_pci_i ? pci_pf_take_i : pf_cpu_take)
  );

  cad_fifo #(.W(32), .DEPTH(DMA_DEPTH)) u_dma_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .push_i(dma_dir_i ? mem_dma_push_i : pci_dma_push_i),
    .data_i(dma_dir_i ? mem_dma_data_i : pci_dma_data_i),
    .ready_o(dma_ready_o),
    .valid_o(dma_valid_o),
    .data_o(dma_data_o),
    .take_i(dma_take_i)
  );

  // ==========================================================
  // outputs
  assign cpu_read_data_o = st_reg.rdata;
  assign ext_data_valid_n_o = st_reg.evalid_n;
  assign cpu_wr_ready_o = wr_ready;
  assign cpu_big_endian_bit_o = st_reg.big_endian;
  assign req_o = st_reg.req;
  assign mem_req_o = st_reg.mem_req;
  assign target_o = st_reg.target;
  assign txn_addr_o = st_reg.addr;
  assign txn_write_o = st_reg.write;
  assign txn_block_o = st_reg.block;
  assign recovery_boot_o = st_reg.recovery;
  assign sel_mem_type_o = st_reg.sel_type;
  assign sel_interleave_o = st_reg.sel_il;
  assign sel_mux_mode_o = st_reg.sel_mux;
  assign bus_err_o = st_reg.bus_err;
  assign cfg_err_o = st_reg.cfg_err;
  assign mem_rd_ready_o = pf_ready;
  assign pci_pf_valid_o = pf_valid;
  assign pci_pf_data_o = pf_data;

endmodule

/* bench/cad_decoder_chk.sv */
`timescale 1ns/1ps
module cad_decoder_chk #(
  parameter int BLOCK_WORDS = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched inputs
  input wire logic [11:0] memory_mux_address_bus_i,
  input wire logic [1:0] boot_rom_size_i,
  input wire logic alt_rd_valid_i,
  input wire logic [31:0] alt_rd_data_i,
  // watched outputs
  input wire logic [31:0] cpu_read_data_o,
  input wire logic ext_data_valid_n_o,
  input wire logic cpu_big_endian_bit_o,
  input wire logic req_o,
  input wire logic mem_req_o,
  input wire logic [cad_pkg::NUM_TARGETS-1:0] target_o,
  input wire logic [31:0] txn_addr_o,
  input wire logic txn_write_o,
  input wire logic txn_block_o,
  input wire logic recovery_boot_o,
  input wire logic [2:0] sel_mem_type_o,
  input wire logic sel_interleave_o,
  input wire logic [2:0] sel_mux_mode_o,
  input wire logic bus_err_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // helpers
  function automatic logic [31:0] swap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  logic strap_bit;
  logic reg_hit;
  logic boot_hit;
  assign strap_bit = memory_mux_address_bus_i[cad_pkg::STRAP_BIT];
  assign reg_hit = txn_addr_o[31:9] == cad_pkg::REG_BASE[31:9];
  assign boot_hit = txn_addr_o[31:24] == cad_pkg::BOOT_REGION &&
                    {1'h0, ~txn_addr_o[23:21]} < (4'h1 << boot_rom_size_i);

  // ==========================================================
  // properties
  sequence s_reset_leave;
    rst_n_i && !$past(rst_n_i);
  endsequence
  sequence s_reg_read;
    req_o && target_o[cad_pkg::T_REG] && !txn_write_o && !txn_block_o && alt_rd_valid_i;
  endsequence
  sequence s_word_back;
    !ext_data_valid_n_o && cpu_read_data_o ==
      (cpu_big_endian_bit_o ? swap($past(alt_rd_data_i)) : $past(alt_rd_data_i));
  endsequence
  property p_strap;
    s_reset_leave |=> cpu_big_endian_bit_o == $past(strap_bit);
  endproperty
  property p_read_paced;
    s_reg_read |=> s_word_back;
  endproperty
  property p_mem_req;
    req_o |-> mem_req_o == !(target_o[cad_pkg::T_REG] || |target_o[9:7]);
  endproperty
  property p_onehot;
    req_o |-> $onehot(target_o);
  endproperty
  property p_reg_window;
    req_o && reg_hit |-> target_o[cad_pkg::T_REG] && !mem_req_o;
  endproperty
  property p_boot_window;
    req_o && boot_hit && !reg_hit |-> target_o[cad_pkg::T_BOOT] && mem_req_o && !recovery_boot_o;
  endproperty
  property p_recovery;
    recovery_boot_o |-> target_o[cad_pkg::T_BOOT];
  endproperty
  property p_base_sdram;
    req_o && target_o[2] && sel_mem_type_o == cad_pkg::MEM_SD16 |->
      !sel_interleave_o && sel_mux_mode_o == cad_pkg::SD16_BASE_MUX;
  endproperty
  property p_base_type;
    req_o && target_o[2] |-> sel_mem_type_o inside {cad_pkg::MEM_EDO, cad_pkg::MEM_SD16};
  endproperty
  property p_mux_mode;
    mem_req_o |-> sel_mux_mode_o < cad_pkg::NUM_MUX_MODES &&
      (sel_mux_mode_o != cad_pkg::SD64_MUX_MODE || sel_mem_type_o == cad_pkg::MEM_SD64);
  endproperty
  property p_err_alone;
    bus_err_o |-> !req_o && !mem_req_o;
  endproperty

  a_strap: assert property (p_strap) else $error("byte order strap not taken");
  a_read_paced: assert property (p_read_paced) else $error("read word not returned");
  a_mem_req: assert property (p_mem_req) else $error("memory request mismatch");
  a_onehot: assert property (p_onehot) else $error("target not one-hot");
  a_reg_window: assert property (p_reg_window) else $error("register window missed");
  a_boot_window: assert property (p_boot_window) else $error("boot window missed");
  a_recovery: assert property (p_recovery) else $error("recovery without boot");
  a_base_sdram: assert property (p_base_sdram) else $error("base sdram setting");
  a_base_type: assert property (p_base_type) else $error("base memory type");
  a_mux_mode: assert property (p_mux_mode) else $error("mux mode illegal");
  a_err_alone: assert property (p_err_alone) else $error("error with request");
endmodule

bind cad_decoder cad_decoder_chk #(.BLOCK_WORDS(BLOCK_WORDS)) u_chk (.clock_i, .rst_n_i,
  .memory_mux_address_bus_i, .boot_rom_size_i, .alt_rd_valid_i, .alt_rd_data_i,
  .cpu_read_data_o, .ext_data_valid_n_o, .cpu_big_endian_bit_o, .req_o, .mem_req_o,
  .target_o, .txn_addr_o, .txn_write_o, .txn_block_o, .recovery_boot_o, .sel_mem_type_o,
  .sel_interleave_o, .sel_mux_mode_o, .bus_err_o);

/* bench/cad_cpu_model.sv */
`timescale 1ns/1ps
module cad_cpu_model (
  // clock and flow
  input wire logic clock_i,
  input wire logic wr_ready_i,
  // processor bus
  output logic [31:0] bus_o,
  output logic [4:0] cmd_o,
  output logic valid_n_o
);
  initial begin
    bus_o = 32'h0;
    cmd_o = 5'h0;
    valid_n_o = 1'h1;
  end
  // released lines show the inverse of the last value
  task automatic drop();
    valid_n_o = 1'h1;
    bus_o = ~bus_o;
    cmd_o = ~cmd_o;
  endtask
  // address stays driven; caller drops it or follows with words
  task automatic addr(input logic [31:0] a, input logic w, input logic blk);
    @(posedge clock_i);
    #1;
    bus_o = a;
    cmd_o = {1'h0, w, ~blk, 2'h0};
    valid_n_o = 1'h0;
    @(posedge clock_i);
    #1;
  endtask
  // one word per cycle, each held until taken or for at most 50 cycles
  task automatic words(input logic [7:0][31:0] d, input int n, input logic mem);
    for (int k = 0; k < n; k++) begin
      bus_o = d[k];
      cmd_o = {2'h3, n == 1, 2'h0};
      valid_n_o = 1'h0;
      for (int t = 0; t < 50; t++) begin
        @(posedge clock_i);
        if (!mem || wr_ready_i) break;
      end
      #1;
    end
    drop();
  endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [31:0] a; logic w; int t; logic r;} cad_row_t;
  // ==========================================================
  // signals
  logic clock_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [31:0] bus, rdat, mwd, pfd, dd;
  logic [4:0] cmd;
  logic vld_n, wr_rdy, evn, big, req, mreq, rec, il_o, berr, cerr, mwv, mrr, pfv, drdy, dv;
  logic [9:0] tgt;
  logic [2:0] smt, smm;
  logic [11:0] strap = 12'h000;
  logic [1:0] rom_sz = 2'h0;
  logic [7:0] en = 8'hFF;
  logic [7:0][31:0] base, mask;
  logic [4:0][2:0] mtype, mux;
  logic [4:0] il = 5'h00;
  logic alt_v = 1'h1, mrd_v = 1'h0, pf_pci = 1'h0, pf_take = 1'h1, dir = 1'h1;
  logic mdp = 1'h0, pdp = 1'h0, dtake = 1'h1, mw_take = 1'h1, be = 1'h0;
  logic [31:0] alt_d = 32'h1122_3344, mrd = 32'h0, mdd = 32'h0, pdd = 32'h0;
  logic [7:0][31:0] blk;
  int n_errors = 0;
  int total_checks = 0;
  cad_row_t rows[14] = '{'{32'h0F00_0010, 0, 1, 0}, '{32'h0F00_0020, 1, 1, 0},
    '{32'h1FF0_0000, 0, 0, 0}, '{32'h1F00_0000, 0, -1, 0}, '{32'h0000_0100, 1, 2, 0},
    '{32'h0000_0104, 0, 2, 0}, '{32'h0100_0040, 0, 3, 0}, '{32'h0200_0000, 1, 4, 0},
    '{32'h0300_0000, 0, 5, 0}, '{32'h0400_0000, 0, 0, 1}, '{32'h8000_0000, 1, 7, 0},
    '{32'h9000_0004, 0, 8, 0}, '{32'hA000_0000, 0, 9, 0}, '{32'h7000_0000, 0, -1, 0}};
  logic [2:0] bad_t[4] = '{cad_pkg::MEM_SD64, cad_pkg::MEM_FPM, cad_pkg::MEM_EDO,
    cad_pkg::MEM_SD16};
  logic [2:0] bad_m[4] = '{3'h4, 3'h0, 3'h5, 3'h3};

  always #4 clock_i = ~clock_i;

  cad_decoder uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_muxed_addr_data_bus_i(bus),
    .cpu_command_lines_i(cmd), .cpu_valid_n_i(vld_n), .cpu_read_data_o(rdat),
    .ext_data_valid_n_o(evn), .cpu_wr_ready_o(wr_rdy), .cpu_big_endian_bit_o(big),
    .memory_mux_address_bus_i(strap), .boot_rom_size_i(rom_sz), .range_en_i(en),
    .range_base_i(base), .range_mask_i(mask), .mem_type_i(mtype), .mem_interleave_i(il),
    .mem_mux_mode_i(mux), .req_o(req), .mem_req_o(mreq), .target_o(tgt), .txn_addr_o(),
    .txn_write_o(), .txn_block_o(), .recovery_boot_o(rec), .sel_mem_type_o(smt),
    .sel_interleave_o(il_o), .sel_mux_mode_o(smm), .bus_err_o(berr), .cfg_err_o(cerr),
    .alt_rd_valid_i(alt_v), .alt_rd_data_i(alt_d), .mem_wr_valid_o(mwv), .mem_wr_data_o(mwd),
    .mem_wr_take_i(mw_take), .mem_rd_valid_i(mrd_v), .mem_rd_data_i(mrd), .mem_rd_ready_o(mrr),
    .pf_to_pci_i(pf_pci), .pci_pf_take_i(pf_take), .pci_pf_valid_o(pfv), .pci_pf_data_o(pfd),
    .dma_dir_i(dir), .mem_dma_push_i(mdp), .mem_dma_data_i(mdd), .pci_dma_push_i(pdp),
    .pci_dma_data_i(pdd), .dma_ready_o(drdy), .dma_valid_o(dv), .dma_data_o(dd),
    .dma_take_i(dtake));
  cad_cpu_model cpu (.clock_i(clock_i), .wr_ready_i(wr_rdy), .bus_o(bus), .cmd_o(cmd),
    .valid_n_o(vld_n));

  // ==========================================================
  // tasks
  function automatic logic [31:0] swap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst_n_i = 1'h0;
    strap = {s, 11'h000};
    repeat (10) @(posedge clock_i);
    #1;
    check("ext_valid_n", evn, 1);
    check("req", req, 0);
    check("target", tgt, 0);
    check("wr_ready", wr_rdy, 1);
    check("ready", {mrr, drdy}, 2'h3);
    rst_n_i = 1'h1;
    @(posedge clock_i);
    #1;
    strap = {~s, 11'h000};
    be = s;
    @(posedge clock_i);
    #1;
    check("big_endian", big, s);
  endtask
  task automatic push(input int which, input logic [31:0] d);
    @(posedge clock_i);
    #1;
    if (which == 0) {mrd_v, mrd} = {1'h1, d};
    else if (which == 1) {mdp, mdd} = {1'h1, d};
    else {pdp, pdd} = {1'h1, d};
    @(posedge clock_i);
    #1;
    {mrd_v, mdp, pdp} = 3'h0;
    {mrd, mdd, pdd} = ~{mrd, mdd, pdd};
  endtask
  // polls one output for a valid word and compares it
  task automatic expect_out(input int which, input logic [31:0] exp, input string nm);
    logic hit;
    logic [31:0] d;
    hit = 1'h0;
    for (int t = 0; t < 20 && !hit; t++) begin
      @(posedge clock_i);
      #1;
      hit = which == 0 ? !evn : which == 1 ? mwv : which == 2 ? pfv : dv;
    end
    d = which == 0 ? rdat : which == 1 ? mwd : which == 2 ? pfd : dd;
    check(nm, hit ? d : ~exp, exp);
  endtask
  task automatic access(input logic [31:0] a, input logic w, input int t, input logic r);
    logic [31:0] d;
    logic m;
    d = a ^ 32'hC3C3_C3C3;
    m = t == 0 || (t >= 2 && t <= 6);
    cpu.addr(a, w, 1'h0);
    check("req", req, t >= 0);
    check("bus_err", berr, t < 0);
    if (t < 0) begin
      cpu.drop();
      return;
    end
    check("target", tgt, 10'h001 << t);
    check("mem_req", mreq, m);
    check("recovery", rec, r);
    check("mem_type", smt, m && t > 0 ? mtype[t-2] : 3'h0);
    if (w) begin
      cpu.words({8{d}}, 1, m);
      if (m) expect_out(1, be ? swap(d) : d, "mem_wr_data");
    end else begin
      cpu.drop();
      if (m) push(0, d);
      expect_out(0, m ? (be ? swap(d) : d) : (be ? swap(alt_d) : alt_d), "rd_data");
    end
  endtask

  // ==========================================================
  // tests
  initial begin
    // windows set up before any access
    base = {32'hA000_0000, 32'h9000_0000, 32'h8000_0000, 32'h0400_0000, 32'h0300_0000,
      32'h0200_0000, 32'h0100_0000, 32'h0000_0000};
    mask = {{3{32'hF000_0000}}, {5{32'hFF00_0000}}};
    mtype = {cad_pkg::MEM_FLASH, cad_pkg::MEM_SD16, cad_pkg::MEM_FPM, cad_pkg::MEM_EDO,
      cad_pkg::MEM_EDO};
    mux = {3'h0, 3'h3, 3'h0, 3'h2, 3'h1};
    do_reset(1'h0);
    foreach (rows[i]) access(rows[i].a, rows[i].w, rows[i].t, rows[i].r);
    for (int i = 0; i < 4; i++) begin
      {mtype[0], mux[0], il[0]} = {bad_t[i], bad_m[i], 1'h1};
      access(32'h0000_0300, 1'h0, i == 3 ? 2 : -1, 1'h0);
      check("cfg_err", cerr, i != 3);
    end
    check("interleave", il_o, 0);
    check("mux_mode", smm, 3);
    {mtype[0], mux[0], il[0]} = {cad_pkg::MEM_EDO, 3'h1, 1'h0};
    rom_sz = 2'h3;
    access(32'h1F00_0000, 1'h0, 0, 1'h0);
    en = 8'hFD;
    access(32'h0100_0000, 1'h0, -1, 1'h0);
    en = 8'hFF;
    mw_take = 1'h0;
    for (int k = 0; k < 8; k++) blk[k] = 32'hB000_0000 | 32'(k);
    cpu.addr(32'h0000_0400, 1'h1, 1'h1);
    cpu.words(blk, 8, 1'h1);
    repeat (3) @(posedge clock_i);
    #1;
    check("wr_full", wr_rdy, 0);
    check("fifo_word", mwd, blk[0]);
    mw_take = 1'h1;
    for (int k = 1; k < 8; k++) expect_out(1, blk[k], "fifo_word");
    pf_pci = 1'h1;
    push(0, 32'h5A00_0001);
    expect_out(2, 32'h5A00_0001, "pci_prefetch");
    pf_pci = 1'h0;
    push(1, 32'h6B00_0002);
    expect_out(3, 32'h6B00_0002, "dma_to_pci");
    dir = 1'h0;
    push(2, 32'h7C00_0003);
    expect_out(3, 32'h7C00_0003, "dma_to_mem");
    do_reset(1'h1);
    access(32'h0F00_0040, 1'h0, 1, 1'h0);
    access(32'h0100_0080, 1'h1, 3, 1'h0);
    access(32'h0100_0084, 1'h0, 3, 1'h0);
    cpu.addr(32'h0F00_0000, 1'h0, 1'h1);
    cpu.drop();
    for (int k = 0; k < 8; k++) expect_out(0, swap(alt_d), "block_read");
    final_report();
  end

  // whole run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule
